/* File: rtl/sfs_consts.svh */
// Offsets, field positions, reset values and timing counts of the supervisor
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH

`define SFS_AW 8
`define SFS_ADDR_CFG 8'h00
`define SFS_ADDR_PERR 8'h04
`define SFS_ADDR_SERR 8'h08
`define SFS_ADDR_STAT 8'h0C
`define SFS_RESP_OKAY 2'h0
`define SFS_RESP_SLVERR 2'h2

// Configuration word
`define SFS_CFG_OVACT 0
`define SFS_CFG_SEC_LO 0
`define SFS_CFG_SEC_HI 3
`define SFS_CFG_PRI_LO 4
`define SFS_CFG_PRI_HI 7
`define SFS_CFG_INJ_PRI 8
`define SFS_CFG_INJ_SEC 9
`define SFS_CFG_RESET 4'h0

// Primary error flags
`define SFS_PERR_RST1 0
`define SFS_PERR_CER1 1
`define SFS_PERR_PAR1 2
`define SFS_PERR_W 3

// Secondary error flags
`define SFS_SERR_UV2 0
`define SFS_SERR_OV2 1
`define SFS_SERR_UV3 2
`define SFS_SERR_OV3 3
`define SFS_SERR_CER2 4
`define SFS_SERR_PAR2 5
`define SFS_SERR_W 6

// Status word
`define SFS_STAT_LIVE_LO 0
`define SFS_STAT_LIVE_HI 3
`define SFS_STAT_COMM 4
`define SFS_STAT_UV1 5
`define SFS_STAT_PRUN 6
`define SFS_STAT_SRUN 7
`define SFS_STAT_TOFF 8

// Synchronised pin inputs
`define SFS_NPIN 8
`define SFS_PIN_UV1 0
`define SFS_PIN_UV2 1
`define SFS_PIN_OV2 2
`define SFS_PIN_UV3 3
`define SFS_PIN_OV3 4
`define SFS_PIN_RST2 5
`define SFS_PIN_PRIMARY_REFERENCE_PIN 6
`define SFS_PIN_SECONDARY_REFERENCE_PIN 7

// Lifesign timing
`define SFS_CLK_NS 50
`define SFS_T_LS_NS 10000
`define SFS_T_LSMIN_NS 7500
`define SFS_T_LSMAX_NS 12500
`define SFS_LS_PERIOD_CYC (`SFS_T_LS_NS / `SFS_CLK_NS)
`define SFS_LS_MIN_CYC ((`SFS_T_LSMIN_NS + `SFS_CLK_NS - 1) / `SFS_CLK_NS)
`define SFS_LS_MAX_CYC (`SFS_T_LSMAX_NS / `SFS_CLK_NS)
`define SFS_LS_CW 9
`define SFS_LS_FAILS 2

`endif

/* File: rtl/sfs_pkg.sv */
// Types shared by the supervisor modules
`include "sfs_consts.svh"
package sfs_pkg;
    typedef logic [31:0] sfs_word_t;
    typedef logic [`SFS_LS_CW-1:0] sfs_lscnt_t;
    typedef logic [1:0] sfs_fails_t;
endpackage

/* File: rtl/sfs_lifesign_wd.sv */
// Lifesign window watchdog kept by one die on the other die's lifesign
`include "sfs_consts.svh"
module sfs_lifesign_wd (
    input wire logic clk_sys, // System clock
    input wire logic rstn, // Async reset, active low
    input wire logic run, // Watching die out of reset
    input wire logic lsIn, // Lifesign pulse from the far die
    output logic lossEvent, // One-cycle class B event
    output logic linkOk // Link present
);
    sfs_pkg::sfs_lscnt_t cnt_ff;
    sfs_pkg::sfs_fails_t fails_ff;
    logic bad;

    // Early lifesign or none by the window end both count as errors
    assign bad = lsIn ? (cnt_ff < `SFS_LS_CW'(`SFS_LS_MIN_CYC))
                      : (cnt_ff >= `SFS_LS_CW'(`SFS_LS_MAX_CYC));

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= '0;
        end else if (!run || lsIn || bad) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + `SFS_LS_CW'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fails_ff <= '0;
            lossEvent <= 1'b0;
            linkOk <= 1'b0;
        end else if (!run) begin
            fails_ff <= '0;
            lossEvent <= 1'b0;
            linkOk <= 1'b0;
        end else begin
            lossEvent <= 1'b0;
            if (bad) begin
                if (fails_ff == 2'(`SFS_LS_FAILS - 1)) begin
                    lossEvent <= 1'b1;
                    linkOk <= 1'b0;
                end
                if (fails_ff != 2'(`SFS_LS_FAILS)) begin
                    fails_ff <= fails_ff + 2'h1;
                end
            end else if (lsIn) begin
                fails_ff <= '0;
                linkOk <= 1'b1;
            end
        end
    end
endmodule

/* File: rtl/sfs_supervisor.sv */
// Supply and internal fault supervisor with AXI4-Lite register slave
`include "sfs_consts.svh"
module sfs_supervisor (
    input wire logic clk_sys, // System clock
    input wire logic rstn, // Async reset, active low
    input wire logic vcc1UvComp, // Primary undervoltage comparator
    input wire logic vcc2UvComp, // Secondary positive undervoltage
    input wire logic vcc2OvComp, // Secondary positive overvoltage
    input wire logic vee2UvComp, // Negative supply undervoltage
    input wire logic vee2OvComp, // Negative supply overvoltage
    input wire logic vcc2RstComp, // Secondary supply below reset level
    input wire logic iref1Fault, // Primary reference pin open/short
    input wire logic iref2Fault, // Secondary reference pin open
    output logic resetReadyN, // Reset/ready pin, low = asserted
    output logic faultBN, // Fault B pin, low = active
    output logic emergencyTurnOff, // Emergency regular turn-off request
    output logic primDieRstN, // Primary die logic reset
    output logic secDieRstN, // Secondary die logic reset
    input wire logic [`SFS_AW-1:0] awaddr, // Write address
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Write byte strobes
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    output logic [1:0] bresp, // Write response
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire logic [`SFS_AW-1:0] araddr, // Read address
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    output sfs_pkg::sfs_word_t rdata, // Read data
    output logic [1:0] rresp, // Read response
    output logic rvalid, // Read data valid
    input wire logic rready // Read data ready
);
    logic [`SFS_NPIN-1:0] pinRaw, s1_ff, s2_ff, s3_ff, live_ff, agree;
    logic uv1D_ff;
    logic [3:0] secCfg_ff, priCfg_ff;
    logic secPar_ff, priPar_ff, secParFail, priParFail;
    logic [`SFS_PERR_W-1:0] perr_ff, perrSet, perrClr;
    logic [`SFS_SERR_W-1:0] serr_ff, serrSet, serrClr;
    logic vee2OvAct, toffCause, fltBCause, priRun, secRun;
    logic [1:0] dieRun, lsPulse_ff, lossEvent, linkOk;
    sfs_pkg::sfs_lscnt_t lsGen_ff [2];
    logic [`SFS_AW-1:0] awAddr_ff;
    sfs_pkg::sfs_word_t wData_ff;
    logic [3:0] wStrb_ff;
    logic doWrite, mappedW;
    sfs_pkg::sfs_word_t rdMux;
    logic mappedR;

    assign pinRaw = {iref2Fault, iref1Fault, vcc2RstComp, vee2OvComp,
                     vee2UvComp, vcc2OvComp, vcc2UvComp, vcc1UvComp};
    assign agree = ~(s2_ff ^ s3_ff);

    // Three-stage sync; a change counts once stages two and three agree
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            live_ff <= '0;
        end else begin
            s1_ff <= pinRaw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            live_ff <= (agree & s3_ff) | (~agree & live_ff);
        end
    end

    // Even parity over each die's configuration
    assign secParFail = (^secCfg_ff) ^ secPar_ff;
    assign priParFail = (^priCfg_ff) ^ priPar_ff;
    assign vee2OvAct = secCfg_ff[`SFS_CFG_OVACT];

    assign priRun = !live_ff[`SFS_PIN_UV1] && !live_ff[`SFS_PIN_PRIMARY_REFERENCE_PIN]
                    && !priParFail;
    assign secRun = !live_ff[`SFS_PIN_RST2] && !live_ff[`SFS_PIN_SECONDARY_REFERENCE_PIN]
                    && !secParFail;
    assign dieRun = {secRun, priRun};

    // Cause goes away with the supply, so the driver may be re-enabled
    assign toffCause = live_ff[`SFS_PIN_UV1]
        | live_ff[`SFS_PIN_UV2] | live_ff[`SFS_PIN_OV2]
        | live_ff[`SFS_PIN_UV3]
        | (live_ff[`SFS_PIN_OV3] & vee2OvAct)
        | live_ff[`SFS_PIN_SECONDARY_REFERENCE_PIN] | secParFail
        | priParFail;
    // Comm loss is a class B event and keeps fault B until cleared
    assign fltBCause = live_ff[`SFS_PIN_UV2] | live_ff[`SFS_PIN_OV2]
        | live_ff[`SFS_PIN_UV3]
        | (live_ff[`SFS_PIN_OV3] & vee2OvAct)
        | priParFail
        | perr_ff[`SFS_PERR_CER1] | serr_ff[`SFS_SERR_CER2];

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            resetReadyN <= 1'b0;
            faultBN <= 1'b1;
            emergencyTurnOff <= 1'b0;
            primDieRstN <= 1'b0;
            secDieRstN <= 1'b0;
        end else begin
            resetReadyN <= priRun;
            faultBN <= !fltBCause;
            emergencyTurnOff <= toffCause;
            primDieRstN <= priRun;
            secDieRstN <= secRun;
        end
    end

    // Lifesign generator of die d is checked by the watchdog of the other
    genvar d;
    generate
        for (d = 0; d < 2; d++) begin : g_die
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    lsGen_ff[d] <= '0;
                    lsPulse_ff[d] <= 1'b0;
                end else if (!dieRun[d]) begin
                    lsGen_ff[d] <= '0;
                    lsPulse_ff[d] <= 1'b0;
                end else if (lsGen_ff[d] ==
                             `SFS_LS_CW'(`SFS_LS_PERIOD_CYC - 1)) begin
                    lsGen_ff[d] <= '0;
                    lsPulse_ff[d] <= 1'b1;
                end else begin
                    lsGen_ff[d] <= lsGen_ff[d] + `SFS_LS_CW'(1);
                    lsPulse_ff[d] <= 1'b0;
                end
            end
            sfs_lifesign_wd u_wd (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .run(dieRun[d]),
                .lsIn(lsPulse_ff[1-d]),
                .lossEvent(lossEvent[d]),
                .linkOk(linkOk[d])
            );
        end
    endgenerate

    // Sticky flags: a set in the clearing cycle wins
    always_comb begin
        perrSet = '0;
        perrSet[`SFS_PERR_RST1] = uv1D_ff && !live_ff[`SFS_PIN_UV1];
        perrSet[`SFS_PERR_CER1] = lossEvent[0];
        perrSet[`SFS_PERR_PAR1] = priParFail;
        serrSet = '0;
        serrSet[`SFS_SERR_UV2] = live_ff[`SFS_PIN_UV2];
        serrSet[`SFS_SERR_OV2] = live_ff[`SFS_PIN_OV2];
        serrSet[`SFS_SERR_UV3] = live_ff[`SFS_PIN_UV3];
        serrSet[`SFS_SERR_OV3] = live_ff[`SFS_PIN_OV3];
        serrSet[`SFS_SERR_CER2] = lossEvent[1];
        serrSet[`SFS_SERR_PAR2] = secParFail;
    end

    assign perrClr = (doWrite && awAddr_ff == `SFS_ADDR_PERR && wStrb_ff[0])
                     ? wData_ff[`SFS_PERR_W-1:0] : '0;
    assign serrClr = (doWrite && awAddr_ff == `SFS_ADDR_SERR && wStrb_ff[0])
                     ? wData_ff[`SFS_SERR_W-1:0] : '0;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            uv1D_ff <= 1'b0;
            perr_ff <= '0;
            serr_ff <= '0;
        end else begin
            uv1D_ff <= live_ff[`SFS_PIN_UV1];
            perr_ff <= (perr_ff & ~perrClr) | perrSet;
            serr_ff <= (serr_ff & ~serrClr) | serrSet;
        end
    end

    // Configuration with stored parity; inject bits corrupt it for test
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            secCfg_ff <= `SFS_CFG_RESET;
            priCfg_ff <= `SFS_CFG_RESET;
            secPar_ff <= 1'b0;
            priPar_ff <= 1'b0;
        end else if (doWrite && awAddr_ff == `SFS_ADDR_CFG) begin
            if (wStrb_ff[0]) begin
                secCfg_ff <= wData_ff[`SFS_CFG_SEC_HI:`SFS_CFG_SEC_LO];
                priCfg_ff <= wData_ff[`SFS_CFG_PRI_HI:`SFS_CFG_PRI_LO];
                secPar_ff <= (^wData_ff[`SFS_CFG_SEC_HI:`SFS_CFG_SEC_LO])
                    ^ (wStrb_ff[1] & wData_ff[`SFS_CFG_INJ_SEC]);
                priPar_ff <= (^wData_ff[`SFS_CFG_PRI_HI:`SFS_CFG_PRI_LO])
                    ^ (wStrb_ff[1] & wData_ff[`SFS_CFG_INJ_PRI]);
            end
        end
    end

    // Write channel: address and data taken in either order
    assign doWrite = !awready && !wready && !bvalid;
    assign mappedW = awAddr_ff == `SFS_ADDR_CFG
        || awAddr_ff == `SFS_ADDR_PERR || awAddr_ff == `SFS_ADDR_SERR
        || awAddr_ff == `SFS_ADDR_STAT;

    // Captured address and data stay put until the response is taken
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            awAddr_ff <= '0;
            wData_ff <= '0;
            wStrb_ff <= '0;
        end else begin
            if (awvalid && awready) begin
                awAddr_ff <= awaddr;
            end
            if (wvalid && wready) begin
                wData_ff <= wdata;
                wStrb_ff <= wstrb;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `SFS_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
            end
            if (doWrite) begin
                bvalid <= 1'b1;
                bresp <= mappedW ? `SFS_RESP_OKAY : `SFS_RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Read data mux; status word is live, not sticky
    always_comb begin
        rdMux = '0;
        mappedR = 1'b1;
        unique case (araddr)
            `SFS_ADDR_CFG: begin
                rdMux[`SFS_CFG_SEC_HI:`SFS_CFG_SEC_LO] = secCfg_ff;
                rdMux[`SFS_CFG_PRI_HI:`SFS_CFG_PRI_LO] = priCfg_ff;
            end
            `SFS_ADDR_PERR: rdMux[`SFS_PERR_W-1:0] = perr_ff;
            `SFS_ADDR_SERR: rdMux[`SFS_SERR_W-1:0] = serr_ff;
            `SFS_ADDR_STAT: begin
                rdMux[`SFS_STAT_LIVE_HI:`SFS_STAT_LIVE_LO] =
                    live_ff[`SFS_PIN_OV3:`SFS_PIN_UV2];
                rdMux[`SFS_STAT_COMM] = linkOk[0];
                rdMux[`SFS_STAT_UV1] = live_ff[`SFS_PIN_UV1];
                rdMux[`SFS_STAT_PRUN] = priRun;
                rdMux[`SFS_STAT_SRUN] = secRun;
                rdMux[`SFS_STAT_TOFF] = toffCause;
            end
            default: mappedR = 1'b0;
        endcase
    end

    // Read data is latched with the address so it holds while rvalid waits
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata <= '0;
            rresp <= `SFS_RESP_OKAY;
        end else if (arvalid && arready) begin
            rdata <= rdMux;
            rresp <= mappedR ? `SFS_RESP_OKAY : `SFS_RESP_SLVERR;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
endmodule

/* File: verif/sfs_supervisor_checker.sv */
// Concurrent checks on the supervisor pins and register bus
module sfs_supervisor_checker (
    input wire logic clk_sys, // Clock
    input wire logic rstn, // Reset
    input wire logic vcc1UvComp, // Primary undervoltage
    input wire logic vcc2UvComp, // Secondary undervoltage
    input wire logic vcc2OvComp, // Secondary overvoltage
    input wire logic vee2UvComp, // Negative undervoltage
    input wire logic vcc2RstComp, // Secondary reset level
    input wire logic iref1Fault, // Primary reference fault
    input wire logic iref2Fault, // Secondary reference fault
    input wire logic resetReadyN, // Reset/ready pin
    input wire logic faultBN, // Fault B pin
    input wire logic emergencyTurnOff, // Turn-off request
    input wire logic primDieRstN, // Primary die reset
    input wire logic secDieRstN, // Secondary die reset
    input wire logic awvalid, // AW valid
    input wire logic awready, // AW ready
    input wire logic wvalid, // W valid
    input wire logic wready, // W ready
    input wire logic bvalid, // B valid
    input wire logic bready, // B ready
    input wire logic arvalid, // AR valid
    input wire logic arready, // AR ready
    input wire logic rvalid, // R valid
    input wire logic rready // R ready
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Six samples cover the three sync stages, the live_ff register and the output register
    sequence sec_supply_bad;
        (vcc2UvComp || vcc2OvComp || vee2UvComp) [*6];
    endsequence
    sequence wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    uv1_lockout_a: assert property (vcc1UvComp [*6] |->
        !resetReadyN && emergencyTurnOff && !primDieRstN)
        else $error("primary undervoltage not acted on");
    sec_supply_a: assert property (sec_supply_bad |->
        !faultBN && emergencyTurnOff)
        else $error("secondary supply fault not acted on");
    ref1_hold_a: assert property (iref1Fault [*6] |->
        !resetReadyN && !primDieRstN)
        else $error("primary reference fault not held");
    ref2_hold_a: assert property (iref2Fault [*6] |->
        emergencyTurnOff && !secDieRstN)
        else $error("secondary reference fault not held");
    sec_reset_a: assert property (vcc2RstComp [*6] |-> !secDieRstN)
        else $error("secondary die not held in reset");
    wr_resp_a: assert property (wr_taken |-> ##[1:2] bvalid)
        else $error("write response missing");
    wr_done_a: assert property (bvalid && bready |=>
        !bvalid && awready && wready)
        else $error("write channel not reopened");
    wr_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    rd_resp_a: assert property (arvalid && arready |=> rvalid)
        else $error("read data missing");
    rd_done_a: assert property (rvalid && rready |=> !rvalid && arready)
        else $error("read channel not reopened");
endmodule

bind sfs_supervisor sfs_supervisor_checker i_chk (.*);

/* File: verif/sfs_host_model.sv */
// Register-bus master standing in for the system controller
`include "sfs_consts.svh"
module sfs_host_model (
    input wire logic clk_sys, // Clock
    output logic [`SFS_AW-1:0] awaddr, // Write address
    output logic awvalid, // Write address valid
    input wire logic awready, // Write address ready
    output logic [31:0] wdata, // Write data
    output logic [3:0] wstrb, // Byte strobes
    output logic wvalid, // Write data valid
    input wire logic wready, // Write data ready
    input wire logic [1:0] bresp, // Write response
    input wire logic bvalid, // Response valid
    output logic bready, // Response ready
    output logic [`SFS_AW-1:0] araddr, // Read address
    output logic arvalid, // Read address valid
    input wire logic arready, // Read address ready
    input wire sfs_pkg::sfs_word_t rdata, // Read data
    input wire logic [1:0] rresp, // Read response
    input wire logic rvalid, // Read valid
    output logic rready // Read ready
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk_sys);
        {awaddr, wdata, wstrb} <= {a, d, 4'h3};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge clk_sys);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk_sys);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge clk_sys);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule

/* File: verif/sfs_supervisor_bench.sv */
// Self-checking bench for the supply and internal fault supervisor
`include "sfs_consts.svh"
`define CHK(g, e) \
    begin \
        comparisons++; \
        if ((g) !== (e)) begin \
            err_total++; \
            $display("Error at %0t: got %0h expected %0h", $time, g, e); \
        end \
    end
module sfs_supervisor_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys;
    logic rstn;
    logic [7:0] comp;
    wire vcc1UvComp = comp[`SFS_PIN_UV1], vcc2UvComp = comp[`SFS_PIN_UV2],
        vcc2OvComp = comp[`SFS_PIN_OV2], vee2UvComp = comp[`SFS_PIN_UV3],
        vee2OvComp = comp[`SFS_PIN_OV3], vcc2RstComp = comp[`SFS_PIN_RST2],
        iref1Fault = comp[`SFS_PIN_PRIMARY_REFERENCE_PIN], iref2Fault = comp[`SFS_PIN_SECONDARY_REFERENCE_PIN];
    logic resetReadyN, faultBN, emergencyTurnOff, primDieRstN, secDieRstN;
    logic [`SFS_AW-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    sfs_pkg::sfs_word_t rdata;
    logic [31:0] v;
    int err_total = 0;
    int comparisons = 0;

    sfs_supervisor i_dut (.*);
    sfs_host_model i_host (.*);

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic finish_test();
        $display("Mismatches %0d of %0d comparisons", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic setp(input int i, input logic b);
        @(posedge clk_sys);
        comp[i] <= b;
    endtask
    // Pins in order reset/ready, fault B, turn-off, primary, secondary
    task automatic pin(input logic [4:0] e);
        `CHK({resetReadyN, faultBN, emergencyTurnOff, primDieRstN, secDieRstN}, e)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e, input logic [1:0] re);
        i_host.rd(a, v, r);
        `CHK({r, v & m}, {re, e})
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] re);
        i_host.wr(a, d, r);
        `CHK(r, re)
    endtask

    initial begin
        #1000000;
        err_total++;
        finish_test();
    end

    initial begin
        comp = 8'h00;
        rstn = 1'b0;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        wt(600);
        pin(5'h1B);
        rd(`SFS_ADDR_CFG, 32'hFFFFFFFF, 32'h0, `SFS_RESP_OKAY);
        rd(`SFS_ADDR_STAT, 32'hFFFFFFFF, 32'h0D0, `SFS_RESP_OKAY);
        rd(`SFS_ADDR_SERR, 32'hFFFFFFFF, 32'h0, `SFS_RESP_OKAY);
        rd(8'h10, 32'hFFFFFFFF, 32'h0, `SFS_RESP_SLVERR);
        wr(8'h10, 32'hFF, `SFS_RESP_SLVERR);
        wr(`SFS_ADDR_STAT, 32'hFF, `SFS_RESP_OKAY);
        rd(`SFS_ADDR_STAT, 32'h1FF, 32'h0D0, `SFS_RESP_OKAY);
        wr(`SFS_ADDR_CFG, 32'h1, `SFS_RESP_OKAY);
        for (int i = 1; i <= 4; i++) begin
            setp(i, 1'b1);
            wt(8);
            pin(5'h17);
            rd(`SFS_ADDR_STAT, 32'hF, 32'h1 << (i - 1), 2'h0);
            setp(i, 1'b0);
            wt(8);
            pin(5'h1B);
            rd(`SFS_ADDR_SERR, 32'hF, 32'h1 << (i - 1), 2'h0);
            wr(`SFS_ADDR_SERR, 32'hF, `SFS_RESP_OKAY);
            rd(`SFS_ADDR_SERR, 32'hF, 32'h0, 2'h0);
        end
        wr(`SFS_ADDR_CFG, 32'h0, `SFS_RESP_OKAY);
        setp(`SFS_PIN_OV3, 1'b1);
        wt(8);
        pin(5'h1B);
        rd(`SFS_ADDR_SERR, 32'hF, 32'h8, 2'h0);
        setp(`SFS_PIN_OV3, 1'b0);
        // Let the comparator fall through the sync before clearing
        wt(8);
        wr(`SFS_ADDR_SERR, 32'hF, `SFS_RESP_OKAY);
        setp(`SFS_PIN_UV1, 1'b1);
        wt(8);
        pin(5'h0D);
        setp(`SFS_PIN_UV1, 1'b0);
        wt(8);
        pin(5'h1B);
        rd(`SFS_ADDR_PERR, 32'h1, 32'h1, 2'h0);
        wr(`SFS_ADDR_PERR, 32'h7, `SFS_RESP_OKAY);
        // Primary held in reset long enough for two missed lifesigns
        setp(`SFS_PIN_PRIMARY_REFERENCE_PIN, 1'b1);
        wt(8);
        pin(5'h09);
        wt(600);
        `CHK(faultBN, 1'b0)
        rd(`SFS_ADDR_SERR, 32'h10, 32'h10, 2'h0);
        setp(`SFS_PIN_PRIMARY_REFERENCE_PIN, 1'b0);
        wt(700);
        rd(`SFS_ADDR_STAT, 32'h10, 32'h10, 2'h0);
        wr(`SFS_ADDR_SERR, 32'h3F, `SFS_RESP_OKAY);
        wr(`SFS_ADDR_PERR, 32'h7, `SFS_RESP_OKAY);
        wt(600);
        rd(`SFS_ADDR_SERR, 32'h10, 32'h0, 2'h0);
        `CHK(faultBN, 1'b1)
        // Fault B follows only later, through the lifesign loss
        setp(`SFS_PIN_SECONDARY_REFERENCE_PIN, 1'b1);
        wt(8);
        pin(5'h1E);
        wt(600);
        rd(`SFS_ADDR_STAT, 32'h10, 32'h0, 2'h0);
        rd(`SFS_ADDR_PERR, 32'h2, 32'h2, 2'h0);
        setp(`SFS_PIN_SECONDARY_REFERENCE_PIN, 1'b0);
        wt(700);
        rd(`SFS_ADDR_STAT, 32'h10, 32'h10, 2'h0);
        wr(`SFS_ADDR_PERR, 32'h7, `SFS_RESP_OKAY);
        wr(`SFS_ADDR_SERR, 32'h3F, `SFS_RESP_OKAY);
        setp(`SFS_PIN_RST2, 1'b1);
        wt(8);
        pin(5'h1A);
        setp(`SFS_PIN_RST2, 1'b0);
        wt(8);
        pin(5'h1B);
        wr(`SFS_ADDR_CFG, 32'h100, `SFS_RESP_OKAY);
        wt(8);
        pin(5'h05);
        rd(`SFS_ADDR_PERR, 32'h4, 32'h4, 2'h0);
        wr(`SFS_ADDR_CFG, 32'h0, `SFS_RESP_OKAY);
        wt(8);
        pin(5'h1B);
        wr(`SFS_ADDR_CFG, 32'h200, `SFS_RESP_OKAY);
        wt(8);
        pin(5'h1E);
        rd(`SFS_ADDR_SERR, 32'h20, 32'h20, 2'h0);
        rd(`SFS_ADDR_CFG, 32'hFFFFFFFF, 32'h0, 2'h0);
        wr(`SFS_ADDR_CFG, 32'h0, `SFS_RESP_OKAY);
        wt(8);
        pin(5'h1B);
        finish_test();
    end
endmodule
